/* File: rtl/rsmc_cfg.svh */
`ifndef RSMC_CFG_SVH
`define RSMC_CFG_SVH

// ====================================================================
// register offsets
`define RSMC_OFS_CTRL0 8'h00
`define RSMC_OFS_CTRL1 8'h04
`define RSMC_OFS_STAT 8'h08

// ====================================================================
// control field positions
`define RSMC_F_PGMODE 0
`define RSMC_F_HALF 2
`define RSMC_F_NWAIT_LO 8
`define RSMC_F_PWAIT_LO 11
`define RSMC_F_PSIZE_LO 13

// ====================================================================
// reset values and codes
`define RSMC_CTRL_RST 32'h0000_0000
`define RSMC_PSIZE_4W 2'h0
`define RSMC_PSIZE_8W 2'h1
`define RSMC_PAGE_4W 4'h4
`define RSMC_PAGE_8W 4'h8
`define RSMC_LOW_UP 4'h0
`define RSMC_LOW_DOWN 4'hC

// ====================================================================
// timing counts
`define RSMC_SYSTEM_CLOCK_PIN_NS 40
`define RSMC_EXT_WAIT_CLK 1
`define RSMC_EXT_WAIT_CYC (`RSMC_EXT_WAIT_CLK * `RSMC_SYSTEM_CLOCK_PIN_NS / 40)
`define RSMC_BURST_WORDS 3'h4
`define RSMC_STRAP_SETTLE 3'h4

`endif

/* File: rtl/rsmc_pkg.sv */
package rsmc_pkg;

  typedef enum logic [1:0] {
    RSMC_SZ_BYTE = 2'h0,
    RSMC_SZ_HALF = 2'h1,
    RSMC_SZ_TRI = 2'h2,
    RSMC_SZ_WORD = 2'h3
  } rsmc_size_t;

  typedef enum logic [2:0] {
    RSMC_SRC_UNCACHED = 3'h0,
    RSMC_SRC_DREFILL1 = 3'h1,
    RSMC_SRC_DBURST = 3'h2,
    RSMC_SRC_IFILL = 3'h3,
    RSMC_SRC_DMA_BURST = 3'h4,
    RSMC_SRC_DMA_SINGLE = 3'h5
  } rsmc_src_t;

  typedef enum logic [2:0] {
    RSMC_ST_IDLE = 3'b000,
    RSMC_ST_EXTW = 3'b001,
    RSMC_ST_SETUP = 3'b011,
    RSMC_ST_WAIT = 3'b010,
    RSMC_ST_STROBE = 3'b110
  } rsmc_state_t;

  typedef struct packed {
    logic [31:0] addr;
    logic we;
    rsmc_size_t size;
    rsmc_src_t src;
    logic chan;
  } rsmc_req_t;

  typedef struct packed {
    logic [31:0] addr;
    logic addr_oe_n;
    logic [3:0] byte_lane_enable_n;
    logic chip_enable_n;
    logic output_enable_n;
    logic static_write_enable_n;
    logic [31:0] data;
    logic data_oe_n;
  } rsmc_mem_t;

endpackage : rsmc_pkg

/* File: rtl/rsmc_sync3.sv */
`timescale 1ns/1ps
module rsmc_sync3 #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic d,
  output logic q
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  // ==================================================================
  // three stages; a level counts once stages two and three agree
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
      q <= RST_VAL;
    end
    else
    begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r)
        q <= s3_r;
    end
  end
endmodule : rsmc_sync3

/* File: rtl/rsmc_page_addr.sv */
`timescale 1ns/1ps
`include "rsmc_cfg.svh"
module rsmc_page_addr
  import rsmc_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic load,
  input wire logic [31:0] start_addr,
  input wire logic step,
  output logic [31:0] word_addr
);
  logic down_r;

  // ==================================================================
  // internal page counter
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      word_addr <= 32'h0000_0000;
      down_r <= 1'b0;
    end
    else if (load)
    begin
      word_addr <= {start_addr[31:2], 2'h0};
      down_r <= (start_addr[3:0] == `RSMC_LOW_DOWN);
    end
    else if (step)
    begin
      if (down_r)
        word_addr <= word_addr - 32'h0000_0004;
      else
        word_addr <= word_addr + 32'h0000_0004;
    end
  end
endmodule : rsmc_page_addr

/* File: rtl/rsmc_ctrl.sv */
// Chosen here: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
`include "rsmc_cfg.svh"
module rsmc_ctrl
  import rsmc_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic req_valid,
  output logic req_ready,
  input wire rsmc_req_t req,
  input wire logic [31:0] req_wdata,
  output logic rsp_valid,
  output logic rsp_last,
  output logic [31:0] rsp_data,
  input wire logic bus_width_strap_pin,
  input wire logic half_speed_n,
  input wire logic bus_cycle_start_n,
  input wire rsmc_req_t ext_req,
  output logic ext_ack_n,
  output rsmc_mem_t mem_o,
  input wire logic [31:0] mem_data_i
);
  logic [31:0] ctrl0_r;
  logic [31:0] ctrl1_r;
  logic [2:0] strap_cnt_r;
  logic strap_done_r;
  logic strap_q;
  logic half_q;
  logic start_n_q;
  logic start_n_d_r;
  logic ext_pend_r;
  logic internal_bus_clock_phase_r;
  rsmc_state_t state_r;
  rsmc_state_t state_nxt;
  rsmc_req_t cur_r;
  logic is_ext_r;
  logic burst_r;
  logic half_r;
  logic page_r;
  logic [2:0] beats_r;
  logic second_r;
  logic [3:0] page_idx_r;
  logic [2:0] wait_r;
  logic [31:0] rdata_r;
  logic [31:0] cnt_addr;
  logic [31:0] ch_ctrl;
  logic adv;
  logic beat_end;
  logic phys_two;
  logic go_int;
  logic go_ext;
  logic wb_hit;
  logic [31:0] wb_mask;

  // ==================================================================
  // helpers
  function automatic logic is_burst(input rsmc_src_t s);
    is_burst = (s == RSMC_SRC_DBURST) || (s == RSMC_SRC_IFILL)
      || (s == RSMC_SRC_DMA_BURST);
  endfunction : is_burst

  function automatic logic [3:0] page_len(input logic [31:0] c);
    page_len = (c[`RSMC_F_PSIZE_LO +: 2] == `RSMC_PSIZE_8W) ?
      `RSMC_PAGE_8W : `RSMC_PAGE_4W;
  endfunction : page_len

  function automatic logic [3:0] lanes_n(input rsmc_size_t sz,
    input logic [1:0] a, input logic hw, input logic sec);
    logic [3:0] r;
    r = 4'hF;
    if (hw)
    begin
      case (sz)
        RSMC_SZ_BYTE: r = a[0] ? 4'hE : 4'hD;
        RSMC_SZ_TRI: r = !sec ? 4'hC : (a[0] ? 4'hE : 4'hD);
        default: r = 4'hC;
      endcase
    end
    else
    begin
      case (sz)
        RSMC_SZ_BYTE: r = ~(4'h8 >> a);
        RSMC_SZ_HALF: r = a[1] ? 4'hC : 4'h3;
        RSMC_SZ_TRI: r = a[0] ? 4'h8 : 4'h1;
        default: r = 4'h0;
      endcase
    end
    lanes_n = r;
  endfunction : lanes_n

  function automatic logic [2:0] fld3(input logic [31:0] c, input int lo);
    fld3 = 3'((c >> lo) & 32'h0000_0007);
  endfunction : fld3

  // ==================================================================
  // pin synchronisers
  rsmc_sync3 #(.RST_VAL(1'b0)) u_strap (
    .clock(clock),
    .rst(rst),
    .d(bus_width_strap_pin),
    .q(strap_q)
  );

  rsmc_sync3 #(.RST_VAL(1'b1)) u_half (
    .clock(clock),
    .rst(rst),
    .d(half_speed_n),
    .q(half_q)
  );

  rsmc_sync3 #(.RST_VAL(1'b1)) u_start (
    .clock(clock),
    .rst(rst),
    .d(bus_cycle_start_n),
    .q(start_n_q)
  );

  // ==================================================================
  // page address counter
  rsmc_page_addr u_cnt (
    .clock(clock),
    .rst(rst),
    .load(go_int || go_ext),
    .start_addr(go_ext ? ext_req.addr : req.addr),
    .step(adv && beat_end && page_r),
    .word_addr(cnt_addr)
  );

  // ==================================================================
  // wishbone register slave
  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
    {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= wb_hit;
      case (wb_adr_i)
        `RSMC_OFS_CTRL0: wb_dat_o <= ctrl0_r;
        `RSMC_OFS_CTRL1: wb_dat_o <= ctrl1_r;
        `RSMC_OFS_STAT: wb_dat_o <= {25'h0, strap_done_r, !half_q,
          is_ext_r, state_r, state_r != RSMC_ST_IDLE};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // strap caught once the synchroniser has settled after release
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      ctrl0_r <= `RSMC_CTRL_RST;
      ctrl1_r <= `RSMC_CTRL_RST;
      strap_cnt_r <= 3'h0;
      strap_done_r <= 1'b0;
    end
    else
    begin
      if (!strap_done_r)
      begin
        strap_cnt_r <= strap_cnt_r + 3'h1;
        if (strap_cnt_r == `RSMC_STRAP_SETTLE)
        begin
          strap_done_r <= 1'b1;
          ctrl0_r[`RSMC_F_HALF] <= strap_q;
        end
      end
      else if (wb_hit && wb_we_i && wb_adr_i == `RSMC_OFS_CTRL0)
        ctrl0_r <= (ctrl0_r & ~wb_mask) | (wb_dat_i & wb_mask);
      if (wb_hit && wb_we_i && wb_adr_i == `RSMC_OFS_CTRL1)
        ctrl1_r <= (ctrl1_r & ~wb_mask) | (wb_dat_i & wb_mask);
    end
  end

  // ==================================================================
  // request intake; external master wins a tie
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      start_n_d_r <= 1'b1;
    else
      start_n_d_r <= start_n_q;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      ext_pend_r <= 1'b0;
    else if (start_n_d_r && !start_n_q)
      ext_pend_r <= 1'b1;
    else if (go_ext)
      ext_pend_r <= 1'b0;
  end

  assign go_ext = (state_r == RSMC_ST_IDLE) && ext_pend_r;
  assign go_int = (state_r == RSMC_ST_IDLE) && !ext_pend_r && req_valid;
  assign req_ready = (state_r == RSMC_ST_IDLE) && !ext_pend_r;
  assign ch_ctrl = ((state_r == RSMC_ST_IDLE) ? (go_ext ? ext_req.chan
    : req.chan) : cur_r.chan) ? ctrl1_r : ctrl0_r;

  // ==================================================================
  // internal bus clock phase for half-speed external accesses
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      internal_bus_clock_phase_r <= 1'b0;
    else
      internal_bus_clock_phase_r <= !internal_bus_clock_phase_r;
  end

  assign adv = !(is_ext_r && !half_q) || internal_bus_clock_phase_r;
  assign phys_two = half_r && (cur_r.size == RSMC_SZ_WORD
    || cur_r.size == RSMC_SZ_TRI);
  assign beat_end = (state_r == RSMC_ST_STROBE)
    && (!phys_two || second_r);

  // ==================================================================
  // access attributes
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      cur_r <= '0;
      is_ext_r <= 1'b0;
      burst_r <= 1'b0;
      half_r <= 1'b0;
      page_r <= 1'b0;
    end
    else if (go_int || go_ext)
    begin
      cur_r <= go_ext ? ext_req : req;
      is_ext_r <= go_ext;
      burst_r <= is_burst(go_ext ? ext_req.src : req.src);
      half_r <= (go_ext ? ext_req.chan : req.chan) ?
        ctrl1_r[`RSMC_F_HALF] : ctrl0_r[`RSMC_F_HALF];
      page_r <= ((go_ext ? ext_req.chan : req.chan) ?
        ctrl1_r[`RSMC_F_PGMODE] : ctrl0_r[`RSMC_F_PGMODE])
        && is_burst(go_ext ? ext_req.src : req.src)
        && !(go_ext ? ext_req.we : req.we);
    end
  end

  // ==================================================================
  // state machine
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      RSMC_ST_IDLE:
        if (go_ext)
          state_nxt = RSMC_ST_EXTW;
        else if (go_int)
          state_nxt = RSMC_ST_SETUP;
      RSMC_ST_EXTW:
        state_nxt = RSMC_ST_SETUP;
      RSMC_ST_SETUP:
        state_nxt = (wait_r == 3'h0) ? RSMC_ST_STROBE : RSMC_ST_WAIT;
      RSMC_ST_WAIT:
        if (wait_r == 3'h1)
          state_nxt = RSMC_ST_STROBE;
      RSMC_ST_STROBE:
        if (beat_end && beats_r == 3'h1)
          state_nxt = RSMC_ST_IDLE;
        else
          state_nxt = RSMC_ST_SETUP;
      default:
        state_nxt = RSMC_ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      state_r <= RSMC_ST_IDLE;
    else if (state_r == RSMC_ST_IDLE || adv)
      state_r <= state_nxt;
  end

  // ==================================================================
  // beat, half and page bookkeeping
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      beats_r <= 3'h0;
      second_r <= 1'b0;
      page_idx_r <= 4'h0;
    end
    else if (go_int || go_ext)
    begin
      beats_r <= is_burst(go_ext ? ext_req.src : req.src) ?
        `RSMC_BURST_WORDS : 3'h1;
      second_r <= 1'b0;
      page_idx_r <= 4'h0;
    end
    else if (adv && state_r == RSMC_ST_STROBE)
    begin
      second_r <= phys_two && !second_r;
      if (beat_end)
        beats_r <= beats_r - 3'h1;
      // a new page opens with full access time
      if (page_idx_r + 4'h1 == page_len(ch_ctrl))
        page_idx_r <= 4'h0;
      else
        page_idx_r <= page_idx_r + 4'h1;
    end
  end

  // wait count: page timing inside an open page, normal otherwise
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      wait_r <= 3'h0;
    else if (adv && state_r == RSMC_ST_WAIT)
      wait_r <= wait_r - 3'h1;
    else if (state_r != RSMC_ST_SETUP && state_nxt == RSMC_ST_SETUP
      && (state_r == RSMC_ST_IDLE || adv))
    begin
      if ((page_r && state_r == RSMC_ST_STROBE
        && page_idx_r + 4'h1 != page_len(ch_ctrl))
        || (ch_ctrl[`RSMC_F_PGMODE] && !cur_r.we && !burst_r
        && phys_two && !second_r && state_r == RSMC_ST_STROBE))
        wait_r <= {1'b0, ch_ctrl[`RSMC_F_PWAIT_LO +: 2]};
      else
        wait_r <= fld3(ch_ctrl, `RSMC_F_NWAIT_LO);
    end
  end

  // ==================================================================
  // memory pins; every output from a flop
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      mem_o <= '{addr: 32'h0, addr_oe_n: 1'b1,
        byte_lane_enable_n: 4'hF, chip_enable_n: 1'b1,
        output_enable_n: 1'b1, static_write_enable_n: 1'b1,
        data: 32'h0, data_oe_n: 1'b1};
    end
    else if (adv)
    begin
      if (state_nxt == RSMC_ST_IDLE || state_nxt == RSMC_ST_EXTW
        || state_r == RSMC_ST_IDLE)
      begin
        // first state of an external access stays off the bus
        mem_o.addr_oe_n <= 1'b1;
        mem_o.chip_enable_n <= 1'b1;
        mem_o.output_enable_n <= 1'b1;
        mem_o.static_write_enable_n <= 1'b1;
        mem_o.data_oe_n <= 1'b1;
        mem_o.byte_lane_enable_n <= 4'hF;
      end
      else
      begin
        // single external access leaves the master's address on the bus
        mem_o.addr_oe_n <= is_ext_r && !page_r;
        if (page_r)
          mem_o.addr <= (half_r && (second_r ^ (state_r ==
            RSMC_ST_STROBE && phys_two))) ?
            cnt_addr + 32'h0000_0002 : cnt_addr;
        else
          mem_o.addr <= (half_r && (second_r ^ (state_r ==
            RSMC_ST_STROBE && phys_two))) ?
            {cur_r.addr[31:2], 2'h2} : cur_r.addr;
        mem_o.byte_lane_enable_n <= lanes_n(cur_r.size, cur_r.addr[1:0],
          half_r, second_r ^ (state_r == RSMC_ST_STROBE && phys_two));
        mem_o.chip_enable_n <= 1'b0;
        mem_o.output_enable_n <= cur_r.we;
        mem_o.static_write_enable_n <= !(cur_r.we
          && state_nxt == RSMC_ST_WAIT);
        mem_o.data_oe_n <= !cur_r.we;
        if (half_r)
          mem_o.data <= {16'h0, (second_r ^ (state_r == RSMC_ST_STROBE
            && phys_two)) ? req_wdata[15:0] : req_wdata[31:16]};
        else
          mem_o.data <= req_wdata;
      end
    end
  end

  // ==================================================================
  // read data and answers; ack runs on the system clock throughout
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      rdata_r <= 32'h0;
      rsp_valid <= 1'b0;
      rsp_last <= 1'b0;
      rsp_data <= 32'h0;
      ext_ack_n <= 1'b1;
    end
    else
    begin
      rsp_valid <= 1'b0;
      rsp_last <= 1'b0;
      ext_ack_n <= 1'b1;
      if (adv && state_r == RSMC_ST_STROBE)
      begin
        if (!half_r)
          rdata_r <= mem_data_i;
        else if (second_r || !phys_two)
          rdata_r <= {rdata_r[31:16], mem_data_i[15:0]};
        else
          rdata_r <= {mem_data_i[15:0], 16'h0};
        if (beat_end)
        begin
          rsp_data <= !half_r ? mem_data_i : (phys_two ?
            {rdata_r[31:16], mem_data_i[15:0]} :
            {mem_data_i[15:0], mem_data_i[15:0]});
          rsp_valid <= !is_ext_r;
          rsp_last <= !is_ext_r && beats_r == 3'h1;
          ext_ack_n <= !is_ext_r;
        end
      end
    end
  end
endmodule : rsmc_ctrl

/* File: bench/rsmc_ctrl_properties.sv */
`timescale 1ns/1ps
module rsmc_ctrl_properties
  import rsmc_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire rsmc_req_t req,
  input wire logic rsp_valid,
  input wire logic rsp_last,
  input wire logic half_speed_n,
  input wire logic bus_cycle_start_n,
  input wire logic ext_ack_n,
  input wire rsmc_mem_t mem_o
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // ==========================================
  // access in flight
  logic take;
  logic act_r;
  logic burst_r;
  logic [2:0] beat_r;
  assign take = req_valid && req_ready;
  always_ff @(posedge clock or posedge rst)
    if (rst) act_r <= 1'b0;
    else if (take) act_r <= 1'b1;
    else if (rsp_last) act_r <= 1'b0;
  always_ff @(posedge clock or posedge rst)
    if (rst) burst_r <= 1'b0;
    else if (take) burst_r <= req.src inside
      {RSMC_SRC_DBURST, RSMC_SRC_IFILL, RSMC_SRC_DMA_BURST};
  always_ff @(posedge clock or posedge rst)
    if (rst) beat_r <= 3'h0;
    else if (take) beat_r <= 3'h0;
    else if (rsp_valid) beat_r <= beat_r + 3'h1;
  // ==========================================
  // properties
  property p_single_beat;
    act_r && !burst_r && rsp_valid |-> rsp_last;
  endproperty
  a_single_beat: assert property (p_single_beat)
    else $error("single access gave extra beats");
  property p_burst_beats;
    act_r && burst_r && rsp_valid |-> rsp_last == (beat_r == 3'h3);
  endproperty
  a_burst_beats: assert property (p_burst_beats)
    else $error("burst beat count wrong");
  // strobes quiet while the outside master still owns the bus
  property p_ext_wait;
    $fell(bus_cycle_start_n) && req_ready |-> (mem_o.chip_enable_n &&
      mem_o.output_enable_n && mem_o.static_write_enable_n &&
      mem_o.addr_oe_n) [*7];
  endproperty
  a_ext_wait: assert property (p_ext_wait)
    else $error("memory driven during inserted wait");
  property p_ext_ack;
    !half_speed_n && !ext_ack_n |=> ext_ack_n;
  endproperty
  a_ext_ack: assert property (p_ext_ack)
    else $error("half speed ack longer than one clock");
  property p_half_pace;
    !half_speed_n && $changed(mem_o.chip_enable_n) |=>
      $stable(mem_o.chip_enable_n);
  endproperty
  a_half_pace: assert property (p_half_pace)
    else $error("half speed strobe moved on system clock");
  property p_take_busy;
    take |=> !req_ready;
  endproperty
  a_take_busy: assert property (p_take_busy)
    else $error("ready while busy");
  property p_wb_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_wb_ack: assert property (p_wb_ack)
    else $error("bus request not acked next cycle");
  property p_wb_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_wb_pulse: assert property (p_wb_pulse)
    else $error("ack held two cycles");
  property p_last_valid;
    rsp_last |-> rsp_valid;
  endproperty
  a_last_valid: assert property (p_last_valid)
    else $error("last without valid");
  c_burst: cover property (act_r && burst_r && rsp_last);
  c_single: cover property (act_r && !burst_r && rsp_last);
  c_ext: cover property (!half_speed_n && !ext_ack_n);
endmodule : rsmc_ctrl_properties

bind rsmc_ctrl rsmc_ctrl_properties rsmc_ctrl_properties_i (
  .clock(clock), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .req_valid(req_valid), .req_ready(req_ready),
  .req(req), .rsp_valid(rsp_valid), .rsp_last(rsp_last),
  .half_speed_n(half_speed_n), .bus_cycle_start_n(bus_cycle_start_n),
  .ext_ack_n(ext_ack_n), .mem_o(mem_o));

/* File: bench/rsmc_mem_model.sv */
`timescale 1ns/1ps
module rsmc_mem_model
  import rsmc_pkg::*;
(
  input wire logic clock,
  input wire logic half,
  input wire rsmc_mem_t mem_o,
  output logic [31:0] mem_data_i
);
  // ==========================================
  // rom contents follow the address
  logic en;
  logic [31:0] wa;
  logic [31:0] drive;
  logic [31:0] last_r = 32'h0000_0000;
  function automatic logic [15:0] hw(input logic [31:0] a);
    return a[15:0] ^ 16'h5AC3;
  endfunction : hw
  assign en = !mem_o.chip_enable_n && !mem_o.output_enable_n;
  assign wa = {mem_o.addr[31:2], 2'b00};
  // upper lanes carry the inverted halfword on a 16-bit bus
  assign drive = half ? {~hw(mem_o.addr), hw(mem_o.addr)} :
    {hw(wa), hw(wa + 32'h2)};
  // released bus shows no stale copy
  assign mem_data_i = en ? drive : ~last_r;
  always_ff @(posedge clock)
    if (en) last_r <= drive;
endmodule : rsmc_mem_model

/* File: bench/tb_rom_static_memory_controller.sv */
`timescale 1ns/1ps
`include "rsmc_cfg.svh"
module tb_rom_static_memory_controller;
  import rsmc_pkg::*;
  logic clock, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, half_bus;
  logic req_valid, req_ready, rsp_valid, rsp_last, ext_ack_n;
  logic bus_width_strap_pin, half_speed_n, bus_cycle_start_n;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, req_wdata, rsp_data, mem_data_i, q;
  logic [31:0] rd [4];
  rsmc_req_t req, ext_req;
  rsmc_mem_t mem_o;
  int error_cnt, check_count, lat, tot, beats, acks, l1, l2, l3;

  rsmc_ctrl rsmc_ctrl_i (.clock(clock), .rst(rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .req_valid(req_valid), .req_ready(req_ready),
    .req(req), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
    .rsp_last(rsp_last), .rsp_data(rsp_data),
    .bus_width_strap_pin(bus_width_strap_pin), .half_speed_n(half_speed_n),
    .bus_cycle_start_n(bus_cycle_start_n), .ext_req(ext_req),
    .ext_ack_n(ext_ack_n), .mem_o(mem_o), .mem_data_i(mem_data_i));
  rsmc_mem_model rsmc_mem_model_i (.clock(clock), .half(half_bus),
    .mem_o(mem_o), .mem_data_i(mem_data_i));

  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // ==========================================
  // helpers
  function automatic logic [31:0] w(input logic [31:0] a);
    return {a[15:0] ^ 16'h5AC3, (a[15:0] + 16'h2) ^ 16'h5AC3};
  endfunction : w
  task check(input logic [31:0] seen, input logic [31:0] exp, string m);
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: %s seen %h want %h", $time, m, seen, exp);
    end
  endtask : check
  task summarize;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  task do_reset(input logic strap);
    @(posedge clock);
    rst <= 1'b1;
    bus_width_strap_pin <= strap;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    repeat (6) @(posedge clock);
  endtask : do_reset
  task wb(input logic [7:0] a, input logic we, input logic [31:0] d);
    int n;
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    for (n = 0; n < 50 && wb_ack_o !== 1'b1; n++) @(posedge clock);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  task cfg(input logic [7:0] a, input logic [31:0] d, input logic h);
    wb(a, 1'b1, d);
    half_bus <= h;
  endtask : cfg
  task acc(rsmc_src_t s, rsmc_size_t z, logic [31:0] a, logic we);
    int n;
    @(posedge clock);
    req_valid <= 1'b1;
    req <= '{addr: a, we: we, size: z, src: s, chan: 1'b0};
    req_wdata <= ~a;
    @(posedge clock);
    for (n = 0; n < 50 && req_ready !== 1'b1; n++) @(posedge clock);
    req_valid <= 1'b0;
    tot = 0;
    beats = 0;
    lat = 0;
    while (rsp_last !== 1'b1 && tot < 200)
    begin
      @(posedge clock);
      tot++;
      if (rsp_valid === 1'b1 && beats < 4) rd[beats] = rsp_data;
      if (rsp_valid === 1'b1) beats++;
      if (beats == 1 && lat == 0) lat = tot;
    end
  endtask : acc
  task ext(input rsmc_src_t s, input int exp);
    int n;
    @(posedge clock);
    ext_req <= '{addr: 32'h0000_0200, we: 1'b0, size: RSMC_SZ_WORD,
      src: s, chan: 1'b1};
    bus_cycle_start_n <= 1'b0;
    acks = 0;
    lat = 0;
    for (n = 1; n < 300 && acks < exp; n++)
    begin
      @(posedge clock);
      if (ext_ack_n === 1'b0) acks++;
      if (acks == 1 && lat == 0) lat = n;
    end
    // attributes held until the last ack, then start lets go
    bus_cycle_start_n <= 1'b1;
    repeat (10)
    begin
      @(posedge clock);
      if (ext_ack_n === 1'b0) acks++;
    end
    check(acks, exp, "outside beats");
  endtask : ext
  // ==========================================
  // scenarios
  task t_regs;
    do_reset(1'b1);
    wb(`RSMC_OFS_CTRL0, 1'b0, 32'h0);
    check(q, 32'h0000_0004, "strap into ch0");
    wb(`RSMC_OFS_STAT, 1'b0, 32'h0);
    check(q[6], 1'b1, "strap done");
    wb(`RSMC_OFS_CTRL1, 1'b0, 32'h0);
    check(q, 32'h0, "ch1 reset");
    wb(8'hFC, 1'b1, 32'hFFFF_FFFF);
    wb(8'hFC, 1'b0, 32'h0);
    check(q, 32'h0, "unmapped");
    wb(`RSMC_OFS_CTRL1, 1'b1, 32'h0000_3B05);
    wb(`RSMC_OFS_CTRL1, 1'b0, 32'h0);
    check(q, 32'h0000_3B05, "ch1 width by software");
    do_reset(1'b0);
    wb(`RSMC_OFS_CTRL0, 1'b0, 32'h0);
    check(q, 32'h0, "strap low");
    $display("test regs done");
  endtask : t_regs
  task t_modes;
    for (int i = 0; i < 6; i++)
    begin
      acc(rsmc_src_t'(i), RSMC_SZ_WORD, 32'h40, 1'b0);
      check(beats, (i inside {2, 3, 4}) ? 4 : 1, "beats");
      check(rd[0], w(32'h40), "first word");
    end
    $display("test modes done");
  endtask : t_modes
  task t_timing;
    cfg(`RSMC_OFS_CTRL0, 32'h0000_0200, 1'b0);
    acc(RSMC_SRC_UNCACHED, RSMC_SZ_WORD, 32'h40, 1'b0);
    l1 = lat;
    acc(RSMC_SRC_UNCACHED, RSMC_SZ_HALF, 32'h40, 1'b0);
    l2 = lat;
    cfg(`RSMC_OFS_CTRL0, 32'h0000_0204, 1'b1);
    acc(RSMC_SRC_UNCACHED, RSMC_SZ_WORD, 32'h40, 1'b0);
    l3 = lat;
    check(rd[0], w(32'h40), "halves joined");
    check(l3 > l1, 1'b1, "two cycles");
    acc(RSMC_SRC_UNCACHED, RSMC_SZ_HALF, 32'h40, 1'b0);
    check(lat, l2, "one cycle");
    cfg(`RSMC_OFS_CTRL0, 32'h0000_0205, 1'b1);
    acc(RSMC_SRC_UNCACHED, RSMC_SZ_WORD, 32'h40, 1'b0);
    check(lat < l3, 1'b1, "page timing single");
    check(rd[0], w(32'h40), "page single data");
    cfg(`RSMC_OFS_CTRL0, 32'h0000_0201, 1'b0);
    acc(RSMC_SRC_UNCACHED, RSMC_SZ_WORD, 32'h40, 1'b0);
    check(lat, l1, "single as normal");
    $display("test timing done");
  endtask : t_timing
  task t_page;
    acc(RSMC_SRC_IFILL, RSMC_SZ_WORD, 32'h100, 1'b0);
    for (int j = 0; j < 4; j++)
      check(rd[j], w(32'h100 + 4 * j), "count up");
    acc(RSMC_SRC_IFILL, RSMC_SZ_WORD, 32'h10C, 1'b0);
    for (int j = 0; j < 4; j++)
      check(rd[j], w(32'h10C - 4 * j), "count down");
    cfg(`RSMC_OFS_CTRL0, 32'h0000_0205, 1'b1);
    acc(RSMC_SRC_DBURST, RSMC_SZ_WORD, 32'h100, 1'b0);
    l1 = tot;
    check(rd[3], w(32'h10C), "16-bit page burst");
    cfg(`RSMC_OFS_CTRL0, 32'h0000_2205, 1'b1);
    acc(RSMC_SRC_DBURST, RSMC_SZ_WORD, 32'h100, 1'b0);
    check(l1 - tot, 2, "one page read less");
    cfg(`RSMC_OFS_CTRL0, 32'h0000_0201, 1'b0);
    acc(RSMC_SRC_DMA_BURST, RSMC_SZ_WORD, 32'h10C, 1'b1);
    check(beats, 4, "burst write");
    $display("test page done");
  endtask : t_page
  task t_ext;
    cfg(`RSMC_OFS_CTRL1, 32'h0000_0100, 1'b0);
    ext(RSMC_SRC_UNCACHED, 1);
    l1 = lat;
    // wait 1 keeps the half speed total even
    half_speed_n <= 1'b0;
    ext(RSMC_SRC_UNCACHED, 1);
    check(lat > l1, 1'b1, "half speed slower");
    half_speed_n <= 1'b1;
    cfg(`RSMC_OFS_CTRL1, 32'h0000_0101, 1'b0);
    ext(RSMC_SRC_IFILL, 4);
    $display("test outside master done");
  endtask : t_ext
  // ==========================================
  // main
  initial
  begin
    rst = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, req_valid, half_bus} = 5'h00;
    {wb_adr_i, wb_dat_i, req_wdata} = 72'h0;
    wb_sel_i = 4'hF;
    bus_width_strap_pin = 1'b1;
    half_speed_n = 1'b1;
    bus_cycle_start_n = 1'b1;
    req = '0;
    ext_req = '0;
    t_regs();
    t_modes();
    t_timing();
    t_page();
    t_ext();
    summarize();
  end
  initial
  begin
    #2000000;
    error_cnt++;
    $display("mismatch at %0t: watchdog expired", $time);
    summarize();
  end
endmodule : tb_rom_static_memory_controller
